//--- rtl/pdc_pkg.sv
// Shared constants for the synthesizer divider chain and serial loader
`default_nettype none
package pdc_pkg;
   // Register widths
   localparam int PRI_W = 21;
   localparam int FEAT_W = 8;
   localparam int MAIN_W = 9;
   localparam int REF_W = 6;
   localparam int SWAL_W = 4;
   // Prescaler moduli
   localparam logic [3:0] PRE_LO_SMALL = 4'h5;
   localparam logic [3:0] PRE_HI_SMALL = 4'hA;
   // Primary register field positions, bit 20 is shifted first
   localparam int PRI_REF54_POS = 19;
   localparam int PRI_MAIN87_POS = 17;
   localparam int PRI_PREDIS_POS = 16;
   localparam int PRI_MAIN60_POS = 9;
   localparam int PRI_REF30_POS = 5;
   localparam int PRI_SWAL_POS = 1;
   localparam int PRI_ADDR_POS = 0;
   // Feature register field positions, bit 7 is shifted first
   localparam int FEAT_MAINOUT_POS = 5;
   localparam int FEAT_PWRDN_POS = 4;
   localparam int FEAT_CNTLOAD_POS = 3;
   localparam int FEAT_MODOUT_POS = 2;
   localparam int FEAT_REFOUT_POS = 1;
   localparam int FEAT_LDDIS_POS = 0;
   // Reset values
   localparam logic [20:0] PRI_RST = 21'h000000;
   localparam logic [7:0] FEAT_RST = 8'h00;
endpackage : pdc_pkg
`default_nettype wire

//--- rtl/pdc_sync.sv
// Two flip-flop synchroniser with rising and falling edge detect
`default_nettype none
module pdc_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Asynchronous level in
   input wire logic d_i,
   // Synchronised level and edges
   output logic q_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_reg; // First stage, read only by second stage
   logic q_reg; // Second stage
   logic prev_reg; // Delayed copy for edges

   // Sync chain
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         q_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
         prev_reg <= q_reg;
      end
   end

   // Edges taken from stable stages only
   assign q_o = q_reg;
   assign rise_o = q_reg & ~prev_reg;
   assign fall_o = ~q_reg & prev_reg;
endmodule : pdc_sync
`default_nettype wire

//--- rtl/pdc_counter.sv
// Down counter dividing an input edge stream by load value plus one
`default_nettype none
module pdc_counter #(
   parameter int W = 9
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Count edge strobe and terminal value
   input wire logic tick_i,
   input wire logic [W-1:0] load_i,
   // Wrap pulse, one per load+1 ticks
   output logic wrap_o
);
   logic [W-1:0] cnt_reg; // Remaining ticks

   // Count down, reload on wrap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
      end else if (tick_i) begin
         if (cnt_reg == '0) begin
            cnt_reg <= load_i;
         end else begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

   // Load of zero wraps on every tick, passing the stream through
   assign wrap_o = tick_i && (cnt_reg == '0);
endmodule : pdc_counter
`default_nettype wire

//--- rtl/pdc_top.sv
// Divider chain, serial loader and phase comparator of the synthesizer
`default_nettype none
module pdc_top #(
   parameter int MAIN_W = pdc_pkg::MAIN_W,
   parameter int REF_W = pdc_pkg::REF_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial programming pins
   input wire logic shift_clk_i,
   input wire logic serial_in_i,
   input wire logic main_load_i,
   input wire logic aux_load_i,
   input wire logic feature_enable_n_i,
   // Mode straps
   input wire logic direct_sel_i,
   input wire logic modulus_choice_i,
   // Direct programming pins
   input wire logic [MAIN_W-1:0] direct_main_i,
   input wire logic [REF_W-1:0] direct_ref_i,
   input wire logic [3:0] direct_swallow_i,
   input wire logic direct_pre_dis_i,
   // Counter clock inputs
   input wire logic rf_in_i,
   input wire logic ref_in_i,
   // Divider and comparator outputs
   output logic main_div_o,
   output logic ref_div_o,
   output logic modulus_select_out_o,
   output logic monitor_out_o,
   output logic pump_up_n_o,
   output logic pump_down_n_o,
   output logic lock_indicator_o,
   output logic power_down_o
);
   // Synchronised pins and edges
   logic sclk_rise, mload_q, mload_rise, aload_q, aload_fall;
   logic serial_in_q, rf_rise, ref_rise, fen_n_q, dsel_q, mchoice_q, pdis_q;
   logic [20:0] pri_reg; // Primary shift register
   logic [20:0] sec_reg; // Secondary holding register
   logic [7:0] fshift_reg; // Feature shift stage
   logic [7:0] fact_reg; // Feature active buffer
   logic [MAIN_W-1:0] main_val; // Effective main value
   logic [REF_W-1:0] ref_val; // Effective reference value
   logic [3:0] swal_val; // Effective swallow value
   logic pre_dis; // Prescaler disabled
   logic big_mod; // 10/11 option chosen
   logic pwr_dn, cnt_load, f_mainout, f_modout, f_refout, f_lddis;
   logic [3:0] pre_cnt_reg; // Prescaler position
   logic [MAIN_W-1:0] swal_left_reg; // Swallow cycles left this period
   logic modulus_select_out; // Larger divisor selected
   logic [3:0] pre_div; // Current prescaler divisor
   logic pre_tick; // Prescaler output strobe
   logic main_tick, main_wrap, ref_wrap;
   logic main_div_reg, ref_div_reg, modulus_select_out_reg, mon_reg;
   logic up_n_reg, dn_n_reg, lock_reg, pwr_reg;

   // Pin synchronisers, one instance with its own edge logic for each single-bit pin
   pdc_sync u_sclk (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(shift_clk_i),
      .q_o(), .rise_o(sclk_rise), .fall_o());
   pdc_sync u_sdat (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(serial_in_i),
      .q_o(serial_in_q), .rise_o(), .fall_o());
   pdc_sync u_mld (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(main_load_i),
      .q_o(mload_q), .rise_o(mload_rise), .fall_o());
   pdc_sync u_ald (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(aux_load_i),
      .q_o(aload_q), .rise_o(), .fall_o(aload_fall));
   pdc_sync u_fen (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(feature_enable_n_i),
      .q_o(fen_n_q), .rise_o(), .fall_o());
   pdc_sync u_dsel (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(direct_sel_i),
      .q_o(dsel_q), .rise_o(), .fall_o());
   pdc_sync u_mch (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(modulus_choice_i),
      .q_o(mchoice_q), .rise_o(), .fall_o());
   pdc_sync u_pdis (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(direct_pre_dis_i),
      .q_o(pdis_q), .rise_o(), .fall_o());
   pdc_sync u_rf (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(rf_in_i),
      .q_o(), .rise_o(rf_rise), .fall_o());
   pdc_sync u_ref (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(ref_in_i),
      .q_o(), .rise_o(ref_rise), .fall_o());

   // Direct bus pins are static straps; two stages still guard them
   logic [MAIN_W+REF_W+3:0] dbus_meta_reg, dbus_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dbus_meta_reg <= '0;
         dbus_reg <= '0;
      end else begin
         dbus_meta_reg <= {direct_main_i, direct_ref_i, direct_swallow_i};
         dbus_reg <= dbus_meta_reg;
      end
   end

   // Primary shift, only while both strobes low
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pri_reg <= pdc_pkg::PRI_RST;
      end else if (sclk_rise && !aload_q && !mload_q) begin
         pri_reg <= {pri_reg[19:0], serial_in_q};
      end
   end

   // Secondary load on main strobe rise, or continuously when enabled
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec_reg <= pdc_pkg::PRI_RST;
      end else if (mload_rise || cnt_load) begin
         sec_reg <= pri_reg;
      end
   end

   // Feature shift stage; never touches the active controls
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fshift_reg <= pdc_pkg::FEAT_RST;
      end else if (sclk_rise && aload_q && !mload_q) begin
         fshift_reg <= {fshift_reg[6:0], serial_in_q};
      end
   end

   // Active buffer captured on aux strobe fall only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fact_reg <= pdc_pkg::FEAT_RST;
      end else if (aload_fall) begin
         fact_reg <= fshift_reg;
      end
   end

   // Feature controls gated by active-low enable
   always_comb begin
      pwr_dn = !fen_n_q && fact_reg[pdc_pkg::FEAT_PWRDN_POS];
      cnt_load = !fen_n_q && fact_reg[pdc_pkg::FEAT_CNTLOAD_POS];
      f_mainout = !fen_n_q && fact_reg[pdc_pkg::FEAT_MAINOUT_POS];
      f_modout = !fen_n_q && fact_reg[pdc_pkg::FEAT_MODOUT_POS];
      f_refout = !fen_n_q && fact_reg[pdc_pkg::FEAT_REFOUT_POS];
      f_lddis = !fen_n_q && fact_reg[pdc_pkg::FEAT_LDDIS_POS];
   end

   // Setting source: direct pins or secondary register
   always_comb begin
      if (dsel_q) begin
         main_val = dbus_reg[REF_W+4 +: MAIN_W];
         ref_val = dbus_reg[4 +: REF_W];
         swal_val = dbus_reg[3:0];
         pre_dis = pdis_q;
      end else begin
         main_val = {sec_reg[pdc_pkg::PRI_MAIN87_POS +: 2],
            sec_reg[pdc_pkg::PRI_MAIN60_POS +: 7]};
         ref_val = {sec_reg[pdc_pkg::PRI_REF54_POS +: 2],
            sec_reg[pdc_pkg::PRI_REF30_POS +: 4]};
         swal_val = sec_reg[pdc_pkg::PRI_SWAL_POS +: 4];
         pre_dis = sec_reg[pdc_pkg::PRI_PREDIS_POS];
      end
      big_mod = mchoice_q;
   end

   // Modulus select: larger divisor while swallow cycles remain
   assign modulus_select_out = (swal_left_reg != '0);
   always_comb begin
      pre_div = big_mod ? pdc_pkg::PRE_HI_SMALL : pdc_pkg::PRE_LO_SMALL;
      if (modulus_select_out) begin
         pre_div = pre_div + 4'h1;
      end
   end

   // Prescaler: counts RF edges, bypassed when disabled
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_cnt_reg <= '0;
      end else if (pre_dis || pwr_dn) begin
         pre_cnt_reg <= '0;
      end else if (rf_rise) begin
         if (pre_cnt_reg >= pre_div - 4'h1) begin
            pre_cnt_reg <= '0;
         end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
         end
      end
   end
   assign pre_tick = rf_rise && (pre_cnt_reg >= pre_div - 4'h1);
   // Bypass feeds RF edges straight to main counter
   assign main_tick = pwr_dn ? 1'b0 : (pre_dis ? rf_rise : pre_tick);

   // Swallow tracker reloads each main period
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         swal_left_reg <= '0;
      end else if (pre_dis || pwr_dn) begin
         swal_left_reg <= '0;
      end else if (main_wrap) begin
         swal_left_reg <= {{(MAIN_W-4){1'b0}}, swal_val};
      end else if (pre_tick && modulus_select_out) begin
         swal_left_reg <= swal_left_reg - 1'b1;
      end
   end

   // Main counter, divides by value plus one; host keeps value >= 1
   pdc_counter #(.W(MAIN_W)) u_main (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .tick_i(main_tick), .load_i(main_val), .wrap_o(main_wrap));

   // Reference counter; value zero wraps on every edge
   pdc_counter #(.W(REF_W)) u_ref_cnt (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .tick_i(ref_rise && !pwr_dn), .load_i(ref_val),
      .wrap_o(ref_wrap));

   // Divided outputs as single-cycle pulses, modulus select as a registered level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_div_reg <= 1'b0;
         ref_div_reg <= 1'b0;
         modulus_select_out_reg <= 1'b0;
      end else begin
         main_div_reg <= main_wrap;
         ref_div_reg <= ref_wrap;
         modulus_select_out_reg <= modulus_select_out;
      end
   end

   // Phase comparator: leading edge drives its pump low until other edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_n_reg <= 1'b1;
         dn_n_reg <= 1'b1;
      end else if (main_wrap && ref_wrap) begin
         up_n_reg <= 1'b1;
         dn_n_reg <= 1'b1;
      end else if (main_wrap) begin
         if (!up_n_reg) begin
            up_n_reg <= 1'b1;
         end else begin
            dn_n_reg <= 1'b0;
         end
      end else if (ref_wrap) begin
         if (!dn_n_reg) begin
            dn_n_reg <= 1'b1;
         end else begin
            up_n_reg <= 1'b0;
         end
      end
   end

   // Monitor pin mux, lock and power state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mon_reg <= 1'b0;
         lock_reg <= 1'b0;
         pwr_reg <= 1'b0;
      end else begin
         if (f_mainout) begin
            mon_reg <= main_wrap;
         end else if (f_modout) begin
            mon_reg <= modulus_select_out;
         end else if (f_refout) begin
            mon_reg <= ref_wrap;
         end else begin
            mon_reg <= 1'b0;
         end
         // Lock is high while neither pump is active, unless disabled
         lock_reg <= !f_lddis && up_n_reg && dn_n_reg;
         pwr_reg <= pwr_dn;
      end
   end

   assign main_div_o = main_div_reg;
   assign ref_div_o = ref_div_reg;
   assign modulus_select_out_o = modulus_select_out_reg;
   assign monitor_out_o = mon_reg;
   assign pump_up_n_o = up_n_reg;
   assign pump_down_n_o = dn_n_reg;
   assign lock_indicator_o = lock_reg;
   assign power_down_o = pwr_reg;

   // Assertions
   sequence main_edge_s;
      main_wrap && !ref_wrap && up_n_reg;
   endsequence
   sequence ref_edge_s;
      ref_wrap && !main_wrap && dn_n_reg;
   endsequence
   shift_primary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sclk_rise && !aload_q && !mload_q) |=> pri_reg[0] == $past(serial_in_q))
      else $error("primary shift missed");
   hold_primary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (aload_q && !mload_q) |=> pri_reg == $past(pri_reg))
      else $error("primary moved during feature shift");
   load_secondary_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mload_rise |=> sec_reg == $past(pri_reg))
      else $error("secondary not loaded");
   feature_capture_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !aload_fall |=> fact_reg == $past(fact_reg))
      else $error("feature changed without capture");
   feature_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fen_n_q |-> !pwr_dn && !cnt_load)
      else $error("feature active while disabled");
   bypass_tick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pre_dis && !pwr_dn) |-> main_tick == rf_rise)
      else $error("bypass not direct");
   down_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      main_edge_s |=> !dn_n_reg)
      else $error("down pump not pulsed");
   up_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ref_edge_s |=> !up_n_reg)
      else $error("up pump not pulsed");
   swallow_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (main_wrap && !pre_dis && !pwr_dn) |=> swal_left_reg[3:0] == $past(swal_val))
      else $error("swallow not reloaded");
   feature_shift_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (sclk_rise && aload_q && !mload_q) |=> fshift_reg[0] == $past(serial_in_q))
      else $error("feature shift missed");
   counter_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_load |=> sec_reg == $past(pri_reg))
      else $error("continuous load missed");
   power_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pwr_dn |-> (!main_tick ##1 pre_cnt_reg == 4'h0))
      else $error("counters run in power down");
endmodule : pdc_top
`default_nettype wire

//--- testbench/pdc_host.sv
// Host controller model driving the serial shift clock, data and load strobes
`default_nettype none
module pdc_host (
   // Clock from the bench
   input wire logic clk_i,
   // Serial programming pins
   output logic shift_clk_o,
   output logic serial_o,
   output logic main_load_o,
   output logic aux_load_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins start low; shift clock idles low between frames, strobes idle low
   initial begin
      shift_clk_o = 1'b0;
      serial_o = 1'b0;
      main_load_o = 1'b0;
      aux_load_o = 1'b0;
   end

   // Shift n bits MSB first, 160 ns per bit, data settled 5 clk before the rise
   task automatic shift_bits(input logic [20:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_i);
         serial_o <= v[i];
         repeat (5) @(posedge clk_i);
         shift_clk_o <= 1'b1;
         repeat (10) @(posedge clk_i);
         shift_clk_o <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      // Released data line shows the inverse, not a stale copy
      serial_o <= ~serial_o;
   endtask

   // Primary frame, optionally committed by a main strobe pulse
   task automatic send_primary(input logic [20:0] v, input bit load);
      shift_bits(v, 21);
      if (load) begin
         @(posedge clk_i);
         main_load_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         main_load_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
   endtask

   // Feature frame bracketed by the aux strobe
   task automatic send_feature(input logic [7:0] v);
      @(posedge clk_i);
      aux_load_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      shift_bits({13'h0000, v}, 8);
      @(posedge clk_i);
      aux_load_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // pdc_host
`default_nettype wire

//--- testbench/test_pdc_top.sv
// Self-checking bench for the divider chain and serial loader
`default_nettype none
module test_pdc_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RFP = 6; // RF period in clk
   localparam int REFP = 8; // Reference period in clk
   localparam int LIMIT = 60000; // Cycle ceiling, well above the worst case
   logic clk_i, rst_n_i, sclk, sdat, mload, aload, fen_n, dsel, mchoice, dpre, rf, rfr;
   logic [8:0] dmain;
   logic [5:0] dref;
   logic [3:0] dswal;
   logic main_div, ref_div, modulus_select_out, mon, up_n, dn_n, lock, pdn;
   int errors, num_checks, cyc, both_lo, up_seen, dn_seen, seed, m, r, a, per, hi;
   bit pd, mc;
   int c_main, c_mon, c_lock, c_pd, c_rdv, c_ms;

   // Device under test
   pdc_top pdc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clk_i(sclk),
      .serial_in_i(sdat), .main_load_i(mload), .aux_load_i(aload),
      .feature_enable_n_i(fen_n), .direct_sel_i(dsel), .modulus_choice_i(mchoice),
      .direct_main_i(dmain), .direct_ref_i(dref), .direct_swallow_i(dswal),
      .direct_pre_dis_i(dpre), .rf_in_i(rf), .ref_in_i(rfr), .main_div_o(main_div),
      .ref_div_o(ref_div), .modulus_select_out_o(modulus_select_out), .monitor_out_o(mon),
      .pump_up_n_o(up_n), .pump_down_n_o(dn_n), .lock_indicator_o(lock),
      .power_down_o(pdn));
   // Far-side host
   pdc_host pdc_host_inst (.clk_i(clk_i), .shift_clk_o(sclk), .serial_o(sdat),
      .main_load_o(mload), .aux_load_o(aload));

   // 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Counter clocks made synchronously so every period is exact in clk
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc % (RFP / 2) == 0) rf <= ~rf;
      if (cyc % (REFP / 2) == 0) rfr <= ~rfr;
      if (cyc == LIMIT) begin
         errors++;
         final_report();
      end
   end

   // Pump watch on settled values
   always @(negedge clk_i) begin
      if (up_n === 1'b0 && dn_n === 1'b0) both_lo++;
      if (up_n === 1'b0) up_seen++;
      if (dn_n === 1'b0) dn_seen++;
   end

   task automatic chk(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         errors++;
         $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
      end
   endtask

   // Cycles to the next pulse, with modulus-select high time over it
   task automatic wait_pulse(input bit sel_ref, output int n, output int h);
      n = 0;
      h = 0;
      do begin
         @(negedge clk_i);
         n++;
         if (modulus_select_out === 1'b1) h++;
      end while (((sel_ref ? ref_div : main_div) !== 1'b1) && n < 6000);
   endtask

   // First interval after a change may be partial, so skip two
   task automatic meas(input bit sel_ref, output int n, output int h);
      repeat (3) wait_pulse(sel_ref, n, h);
   endtask

   // Pulse and level counts over a window
   task automatic window(input int n);
      c_main = 0;
      c_mon = 0;
      c_lock = 0;
      c_pd = 0;
      c_rdv = 0;
      c_ms = 0;
      repeat (n) begin
         @(negedge clk_i);
         if (main_div === 1'b1) c_main++;
         if (mon === 1'b1) c_mon++;
         if (lock === 1'b1) c_lock++;
         if (pdn === 1'b1) c_pd++;
         if (ref_div === 1'b1) c_rdv++;
         if (modulus_select_out === 1'b1) c_ms++;
      end
   endtask

   function automatic int ratio(int mm, int aa, bit p, bit c);
      return p ? mm + 1 : (c ? 10 : 5) * (mm + 1) + aa;
   endfunction

   function automatic logic [20:0] pack(int mm, int rr, int aa, bit p);
      logic [8:0] mv;
      logic [5:0] rv;
      logic [3:0] av;
      mv = mm[8:0];
      rv = rr[5:0];
      av = aa[3:0];
      return {rv[5:4], mv[8:7], p, mv[6:0], rv[3:0], av, 1'b0};
   endfunction

   // Set settings on a clock edge
   task automatic apply(int mm, int rr, int aa, bit p, bit c);
      @(posedge clk_i);
      dmain <= mm[8:0];
      dref <= rr[5:0];
      dswal <= aa[3:0];
      dpre <= p;
      mchoice <= c;
   endtask

   task automatic final_report();
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      rst_n_i = 1'b0;
      rf = 1'b0;
      rfr = 1'b0;
      fen_n = 1'b1;
      dsel = 1'b1;
      mchoice = 1'b0;
      dmain = 9'h001;
      dref = 6'h00;
      dswal = 4'h0;
      dpre = 1'b0;
      errors = 0;
      num_checks = 0;
      cyc = 0;
      both_lo = 0;
      up_seen = 0;
      dn_seen = 0;
      seed = $urandom(73805);
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk(int'(up_n === 1'b1 && dn_n === 1'b1), 1);
      // Direct mode: corners then random settings
      for (int i = 0; i < 8; i++) begin
         m = (i < 2) ? 1 : 1 + $urandom % 20;
         a = (i == 0) ? 2 : $urandom % ((m + 2 > 16) ? 16 : m + 2);
         // Corner 1: fast bypass main against a slow reference, so main leads
         r = (i == 0) ? 0 : (i == 1) ? 3 : $urandom % 8;
         pd = (i == 1) ? 1'b1 : ($urandom % 4 == 0);
         mc = (i == 0) ? 1'b1 : $urandom % 2;
         apply(m, r, a, pd, mc);
         meas(1'b0, per, hi);
         chk(per, ratio(m, a, pd, mc) * RFP);
         chk(hi, pd ? 0 : a * (mc ? 11 : 6) * RFP);
         meas(1'b1, per, hi);
         chk(per, (r + 1) * REFP);
      end
      // Serial programming of the primary register
      @(posedge clk_i);
      dsel <= 1'b0;
      apply(9, 9, 9, 1'b1, 1'b1);
      pdc_host_inst.send_primary(pack(3, 2, 1, 1'b0), 1'b1);
      meas(1'b0, per, hi);
      chk(per, ratio(3, 1, 1'b0, 1'b1) * RFP);
      meas(1'b1, per, hi);
      chk(per, 3 * REFP);
      pdc_host_inst.send_primary(pack(5, 0, 0, 1'b1), 1'b0);
      meas(1'b0, per, hi);
      chk(per, ratio(3, 1, 1'b0, 1'b1) * RFP);
      pdc_host_inst.send_primary(pack(5, 0, 0, 1'b1), 1'b1);
      meas(1'b0, per, hi);
      chk(per, 6 * RFP);
      // Feature register: main-out monitor plus lock disable
      pdc_host_inst.send_feature(8'h21);
      window(300);
      chk(c_mon, 0);
      chk(int'(c_lock > 0), 1);
      @(posedge clk_i);
      fen_n <= 1'b0;
      // Let the enable pass its synchroniser before counting
      repeat (4) @(posedge clk_i);
      window(300);
      chk(c_mon, c_main);
      chk(c_lock, 0);
      // Active controls hold while a new frame shifts in
      fork
         pdc_host_inst.send_feature(8'h10);
         window(150);
      join
      chk(c_pd, 0);
      chk(c_mon, c_main);
      window(100);
      chk(c_pd, 100);
      // Counter load: a frame shifted while powered down, never strobed,
      // takes effect; shifting with the load on would pass half-shifted values
      pdc_host_inst.send_primary(pack(2, 0, 1, 1'b0), 1'b0);
      pdc_host_inst.send_feature(8'h0C);
      meas(1'b0, per, hi);
      chk(per, ratio(2, 1, 1'b0, 1'b1) * RFP);
      chk(hi, 1 * 11 * RFP);
      window(200);
      chk(c_mon, c_ms);
      // Reference pulse on the monitor pin
      pdc_host_inst.send_feature(8'h02);
      window(200);
      chk(c_mon, c_rdv);
      chk(int'(c_rdv > 0), 1);
      // Comparator saw both leads, never both pumps at once
      chk(both_lo, 0);
      chk(int'(up_seen > 0 && dn_seen > 0), 1);
      final_report();
   end
endmodule // test_pdc_top
`default_nettype wire
